// *** dv/aei_mcu.sv ***
`timescale 1ns/1ps
module aei_mcu (
  // Clock
  input  logic        aclk,
  // Write channels
  output logic [7:0]  awaddr,
  output logic        awvalid,
  input  logic        awready,
  output logic [31:0] wdata,
  output logic        wvalid,
  input  logic        wready,
  input  logic [1:0]  bresp,
  input  logic        bvalid,
  output logic        bready,
  // Read channels
  output logic [7:0]  araddr,
  output logic        arvalid,
  input  logic        arready,
  input  logic [31:0] rdata,
  input  logic [1:0]  rresp,
  input  logic        rvalid,
  output logic        rready,
  // Answer seen beside the answer noted
  output logic        chk_stb,
  output logic [33:0] chk_seen,
  output logic [33:0] chk_exp
);
  logic [33:0] exp_q[$];
  logic        aw_done;
  logic        w_done;

  // Idle bus at time zero
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, chk_stb} = '0;
    {awaddr, araddr, wdata, chk_seen, chk_exp} = '0;
  end

  // One write; each channel held until its own ready is seen
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] r);
    begin
      exp_q.push_back({r, 32'h0});
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      aw_done = 1'b0;
      w_done  = 1'b0;
      while (!(aw_done && w_done))
      begin
        @(posedge aclk);
        if (awvalid && awready)
        begin
          aw_done = 1'b1;
          awvalid <= 1'b0;
        end
        if (wvalid && wready)
        begin
          w_done = 1'b1;
          wvalid <= 1'b0;
        end
      end
      while (!bvalid)
        @(posedge aclk);
      bready <= 1'b0;
    end
  endtask

  // One read; rready stays up until the data beat is taken
  task automatic rd(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] r);
    begin
      exp_q.push_back({r, 24'h0, d});
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      @(posedge aclk);
      while (!arready)
        @(posedge aclk);
      arvalid <= 1'b0;
      @(posedge aclk);
      while (!rvalid)
        @(posedge aclk);
      rready <= 1'b0;
    end
  endtask

  // Oldest note leaves the queue when an answer is handed over
  always @(posedge aclk)
  begin
    chk_stb <= 1'b0;
    if (((rvalid && rready) || (bvalid && bready)) && exp_q.size() > 0)
    begin
      chk_stb  <= 1'b1;
      chk_exp  <= exp_q.pop_front();
      chk_seen <= rvalid ? {rresp, rdata} : {bresp, 32'h0};
    end
  end
endmodule // aei_mcu

// *** dv/tb.sv ***
`timescale 1ns/1ps
module tb;
  // Bus and pin wires between the model and the block
  logic [7:0]  awaddr;
  logic [7:0]  araddr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic [1:0]  eq_mode;
  logic [33:0] chk_seen;
  logic [33:0] chk_exp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, chk_stb;
  logic aresetn, coef_bank_switched, irq_out_pin;
  logic aclk = 1'b0;
  // Protection is ignored by the block; only strobe bit 0 is used, to gate the write
  logic [2:0]  awprot = 3'h0;
  logic [2:0]  arprot = 3'h0;
  logic [3:0]  wstrb  = 4'h1;
  aei_pkg::aei_det_t   det_in;
  aei_pkg::aei_speed_t speed_in;
  int          miscompares;
  int          cmp_count;
  int          seed;
  logic [15:0] val;
  logic [15:0] nxt;
  logic [7:0]  ev;
  localparam logic [1:0] OK  = aei_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = aei_pkg::RESP_SLVERR;
  localparam logic [7:0] E   = aei_pkg::OFS_EDGE;
  localparam logic [2:0] DETS [6] = '{3'h1, 3'h0, 3'h2, 3'h0, 3'h4, 3'h0};
  localparam logic [7:0] EVS [6] = '{8'h04, 8'h02, 8'h10, 8'h08, 8'h20, 8'h00};

  aei_top dut_u (.*);
  aei_mcu mcu_u (.*);

  // Free-running bus clock
  always #12.5 aclk = ~aclk;

  // Compare one value against its expectation
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    begin
      cmp_count++;
      if (seen !== exp)
      begin
        miscompares++;
        $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // Pin level, looked at once the edge's updates have landed
  task automatic pin(input logic e);
    begin
      #1;
      check({33'h0, irq_out_pin}, {33'h0, e});
    end
  endtask

  // New detector levels, then two edges to sample and register
  task automatic step(input logic [2:0] d);
    begin
      @(posedge aclk);
      det_in <= d;
      repeat (2) @(posedge aclk);
    end
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic finish_test;
    begin
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  // Bus answers checked as the model hands them over
  always @(posedge aclk)
    if (chk_stb === 1'b1)
      check(chk_seen, chk_exp);

  // A hang is cut short well past the expected run length
  initial
  begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    finish_test;
  end

  // Main sequence
  initial
  begin
    aresetn = 1'b0;
    det_in = 3'h0;
    speed_in = 8'h00;
    coef_bank_switched = 1'b0;
    miscompares = 0;
    cmp_count = 0;
    seed = 32'h5E8BE74A;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    pin(1'b1);
    check({32'h0, eq_mode}, 34'h0);
    mcu_u.rd(aei_pkg::OFS_MASK, 8'h00, OK);
    mcu_u.wr(aei_pkg::OFS_MASK, 8'hFF, OK);
    mcu_u.rd(aei_pkg::OFS_MASK, 8'h00, OK);
    mcu_u.wr(8'h1C, 8'h55, ERR);
    mcu_u.rd(8'h1C, 8'h00, ERR);
    done("reset");
    // Search mode before the mask, as software must do it
    mcu_u.wr(aei_pkg::OFS_EQCTL, 8'h05, OK);
    check({32'h0, eq_mode}, 34'h1);
    mcu_u.rd(aei_pkg::OFS_EQCTL, 8'h05, OK);
    mcu_u.wr(aei_pkg::OFS_MASK, 8'h3F, OK);
    for (int i = 0; i < 6; i++)
    begin
      step(DETS[i]);
      pin(EVS[i] == 8'h00);
      mcu_u.rd(E, EVS[i], OK);
      pin(1'b1);
    end
    done("edges");
    // Second event before the read only piles up in the flags
    step(3'h1);
    pin(1'b0);
    step(3'h3);
    pin(1'b0);
    mcu_u.rd(E, 8'h14, OK);
    mcu_u.rd(E, 8'h00, OK);
    step(3'h0);
    pin(1'b0);
    // Event in the cycle after the read is taken must rearm the pin
    fork
      mcu_u.rd(E, 8'h0A, OK);
      begin
        repeat (2) @(posedge aclk);
        det_in <= 3'h2;
      end
    join
    pin(1'b0);
    mcu_u.rd(E, 8'h10, OK);
    mcu_u.wr(aei_pkg::OFS_MASK, 8'h10, OK);
    step(3'h1);
    pin(1'b1);
    step(3'h0);
    mcu_u.rd(E, 8'h00, OK);
    mcu_u.wr(aei_pkg::OFS_MASK, 8'h3F, OK);
    @(posedge aclk);
    speed_in <= 8'h80;
    step(3'h2);
    pin(1'b1);
    step(3'h0);
    mcu_u.rd(E, 8'h00, OK);
    @(posedge aclk);
    speed_in <= 8'h00;
    done("accumulate");
    // Counter: reach zero both ways (0001 down, FFFF up), then random loads
    for (int i = 0; i < 4; i++)
    begin
      val = (i < 2) ? (i[0] ? 16'hFFFF : 16'h0001) : 16'($random(seed));
      nxt = i[0] ? val + 16'h1 : val - 16'h1;
      ev = (nxt == 16'h0) ? 8'h19 : 8'h18;
      mcu_u.wr(aei_pkg::OFS_EQCTL, {5'h0, i[0], 2'h1}, OK);
      mcu_u.wr(aei_pkg::OFS_CNT_LO, val[7:0], OK);
      mcu_u.wr(aei_pkg::OFS_CNT_HI, val[15:8], OK);
      step(3'h2);
      step(3'h0);
      mcu_u.rd(E, ev, OK);
      mcu_u.rd(aei_pkg::OFS_CNT_LO, nxt[7:0], OK);
      mcu_u.rd(aei_pkg::OFS_CNT_HI, nxt[15:8], OK);
    end
    @(posedge aclk);
    coef_bank_switched <= 1'b1;
    @(posedge aclk);
    coef_bank_switched <= 1'b0;
    mcu_u.rd(E, 8'h80, OK);
    done("counter");
    // Bypass codes; the pin carries the chosen level, active high
    for (int c = 1; c < 4; c++)
    begin
      mcu_u.wr(aei_pkg::OFS_MASK, {c[1:0], 6'h3F}, OK);
      repeat (2)
      begin
        val = 16'($random(seed));
        @(posedge aclk);
        speed_in <= val[15:8];
        step(val[2:0]);
        pin(val[c - 1]);
        mcu_u.rd(aei_pkg::OFS_LIVE, {5'h0, val[2:0]}, OK);
        mcu_u.rd(aei_pkg::OFS_SPEED, val[15:8], OK);
        pin(val[c - 1]);
      end
    end
    done("bypass");
    // Reset in mid-run drops bypass, mask, mode and flags
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    pin(1'b1);
    check({32'h0, eq_mode}, 34'h0);
    mcu_u.rd(E, 8'h00, OK);
    done("reset again");
    repeat (3) @(posedge aclk);
    finish_test;
  end
endmodule // tb

// *** hdl/aei_pkg.sv ***
// Summary of operation
// - Mask register is write-only, sets interrupt mode, resets to all zeros.
// - Without bypass, mask bits 5..0 each enable one of six interrupts: five edges, bit0 count zero.
// - Any bypass bit high: pin carries chosen detector level, not interrupts.
// - Bypass code 00 none, 01 marker, 10 envelope, 11 blank tape.
// - Pin is active low for interrupts, active high for bypassed level.
// - Enabled event drives pin low until edge event register is read.
// - Later events before that read only set flags, no new pin activity.
// - Enabled events after the read raise a fresh interrupt.
// - Reading edge event register clears every flag it returned as set.
// - Edge register: bit7 coefficients active, bit6 test, bits5..0 events.
// - Live level register: bit2 blank, bit1 envelope, bit0 marker.
// - Marker high on marker found; blank means no signal; envelope one bit.
// - Detector info counts only in search mode at valid search speed.
// - Detector outputs lag the input by envelope periods, set upstream.
// - Count-zero event fires when the event counter has just reached zero.
// - 16-bit event counter loaded and read as two bytes, low first.
// - Search speed is two to the range, times 51.2 over value.
// - Search register: bit7 invalid, bits6..2 value, bits1..0 range.
// - Counter steps by one per envelope rise, up or down by direction.
// - Search mode processes only the auxiliary channel envelope.
package aei_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_MASK   = 8'h00;
  localparam logic [7:0] OFS_EDGE   = 8'h04;
  localparam logic [7:0] OFS_LIVE   = 8'h08;
  localparam logic [7:0] OFS_CNT_LO = 8'h0C;
  localparam logic [7:0] OFS_CNT_HI = 8'h10;
  localparam logic [7:0] OFS_SPEED  = 8'h14;
  localparam logic [7:0] OFS_EQCTL  = 8'h18;

  // Field positions
  localparam int unsigned MASK_BP_LSB = 6;
  localparam int unsigned EDGE_COEF_BANK_SWITCHED   = 7;
  localparam int unsigned EQ_DIR_BIT  = 2;
  localparam logic [1:0]  EQ_SEARCH   = 2'h1;

  // Bypass select codes
  localparam logic [1:0] BP_NONE  = 2'h0;
  localparam logic [1:0] BP_MARK  = 2'h1;
  localparam logic [1:0] BP_ENV   = 2'h2;
  localparam logic [1:0] BP_BLANK = 2'h3;

  // Reset values and bus answers
  localparam logic [7:0]  MASK_RST    = 8'h00;
  localparam logic [7:0]  EQCTL_RST   = 8'h00;
  localparam logic [15:0] CNT_RST     = 16'h0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Detector levels, in live level register order
  typedef struct packed {
    logic blank;
    logic env;
    logic marker;
  } aei_det_t;

  // Speed measurement, in search rate register order
  typedef struct packed {
    logic       invalid;
    logic [4:0] value;
    logic [1:0] range;
  } aei_speed_t;

  // One-hot register select
  typedef struct packed {
    logic mask;
    logic edge_ev;
    logic live;
    logic cnt_lo;
    logic cnt_hi;
    logic speed;
    logic eqctl;
  } aei_sel_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'h1,
    RD_RESP = 2'h2
  } aei_rd_t;

  typedef struct packed {
    logic [7:0]  mask;
    logic [7:0]  eqctl;
    logic [7:0]  flags;
    logic        pending;
    logic [15:0] counter;
    logic [7:0]  lo_buf;
    logic [7:0]  hi_snap;
    aei_det_t    prev;
    aei_speed_t  speed;
    logic        irq_pin;
    logic        awready;
    logic        wready;
    logic        aw_held;
    logic        w_held;
    aei_sel_t    wsel;
    logic        wmapped;
    logic [7:0]  wdata;
    logic        wlane;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    aei_rd_t     rd;
    logic        rvalid;
    logic [7:0]  rdata;
    logic [1:0]  rresp;
  } aei_state_t;

endpackage

// *** hdl/aei_top.sv ***
`timescale 1ns/1ps
module aei_top #(
  parameter int unsigned ADDR_W = 8
) (
  // Clock and reset
  input  logic                  aclk,
  input  logic                  aresetn,
  // AXI4-Lite write address and data
  input  logic [ADDR_W-1:0]     awaddr,
  input  logic [2:0]            awprot,
  input  logic                  awvalid,
  output logic                  awready,
  input  logic [31:0]           wdata,
  input  logic [3:0]            wstrb,
  input  logic                  wvalid,
  output logic                  wready,
  // AXI4-Lite write response
  output logic [1:0]            bresp,
  output logic                  bvalid,
  input  logic                  bready,
  // AXI4-Lite read
  input  logic [ADDR_W-1:0]     araddr,
  input  logic [2:0]            arprot,
  input  logic                  arvalid,
  output logic                  arready,
  output logic [31:0]           rdata,
  output logic [1:0]            rresp,
  output logic                  rvalid,
  input  logic                  rready,
  // Envelope detector and speed measurement
  input  aei_pkg::aei_det_t     det_in,
  input  aei_pkg::aei_speed_t   speed_in,
  input  logic                  coef_bank_switched,
  // Equalizer control and interrupt pin
  output logic [1:0]            eq_mode,
  output logic                  irq_out_pin
);

  aei_pkg::aei_state_t st;
  aei_pkg::aei_state_t next_st;

  logic               aw_take;
  logic               w_take;
  logic               ar_take;
  logic               do_write;
  logic               info_valid;
  logic [2:0]         det_v;
  logic [2:0]         rise;
  logic [2:0]         fall;
  logic               cnt_step;
  logic [15:0]        cnt_next;
  logic               cnt_zero;
  logic [5:0]         ev;
  logic [1:0]         bypass;
  logic               edge_read;
  logic [7:0]         clr;
  aei_pkg::aei_sel_t  rsel;

  // Address decode, shared by both channels; unmapped gives all zero
  function automatic aei_pkg::aei_sel_t decode(
    input logic [ADDR_W-1:0] a
  );
    aei_pkg::aei_sel_t s;
    s.mask    = (a == ADDR_W'(aei_pkg::OFS_MASK));
    s.edge_ev = (a == ADDR_W'(aei_pkg::OFS_EDGE));
    s.live    = (a == ADDR_W'(aei_pkg::OFS_LIVE));
    s.cnt_lo  = (a == ADDR_W'(aei_pkg::OFS_CNT_LO));
    s.cnt_hi  = (a == ADDR_W'(aei_pkg::OFS_CNT_HI));
    s.speed   = (a == ADDR_W'(aei_pkg::OFS_SPEED));
    s.eqctl   = (a == ADDR_W'(aei_pkg::OFS_EQCTL));
    return s;
  endfunction

  // Detector level routed to the pin in bypass
  function automatic logic sel_level(
    input logic [1:0] bp,
    input logic [2:0] d
  );
    logic l;
    case (bp)
      aei_pkg::BP_MARK:  l = d[0];
      aei_pkg::BP_ENV:   l = d[1];
      aei_pkg::BP_BLANK: l = d[2];
      default:           l = 1'b1;
    endcase
    return l;
  endfunction

  // Event sources; edges need one registered copy of each level
  always_comb
  begin
    det_v      = det_in;
    // Envelope info only trusted in search mode at a valid speed
    info_valid = (st.eqctl[1:0] == aei_pkg::EQ_SEARCH)
                 && !speed_in.invalid;
    // One cycle of latency is far below an envelope period
    rise       = det_v & ~st.prev;
    fall       = ~det_v & st.prev;
    cnt_step   = info_valid & rise[1];
    if (st.eqctl[aei_pkg::EQ_DIR_BIT])
    begin
      cnt_next = st.counter + 16'h0001;
    end
    else
    begin
      cnt_next = st.counter - 16'h0001;
    end
    cnt_zero   = cnt_step & (cnt_next == 16'h0000);
    // Same order as the mask and flag bits
    ev         = {rise[2], rise[1], fall[1], rise[0], fall[0], 1'b0};
    ev         = (ev & {6{info_valid}}) | {5'h00, cnt_zero};
    ev         = ev & st.mask[5:0];
    bypass     = st.mask[aei_pkg::MASK_BP_LSB +: 2];
  end

  // Next state: bus slave, registers, flags and pin
  always_comb
  begin
    next_st   = st;
    aw_take   = awvalid & st.awready;
    w_take    = wvalid & st.wready;
    ar_take   = arvalid & st.arready;
    rsel      = decode(araddr);
    edge_read = ar_take & rsel.edge_ev;
    clr       = edge_read ? st.flags : 8'h00;
    next_st.prev  = det_v;
    next_st.speed = speed_in;

    // Write channel: address and data taken in either order
    if (aw_take)
    begin
      next_st.aw_held = 1'b1;
      next_st.wsel    = decode(awaddr);
      next_st.wmapped = (decode(awaddr) != '0);
    end
    if (w_take)
    begin
      next_st.w_held = 1'b1;
      next_st.wdata  = wdata[7:0];
      next_st.wlane  = wstrb[0];
    end
    if (st.bvalid && bready)
    begin
      next_st.bvalid = 1'b0;
    end
    do_write = next_st.aw_held & next_st.w_held & ~st.bvalid;
    if (do_write)
    begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = next_st.wmapped ? aei_pkg::RESP_OKAY
                                        : aei_pkg::RESP_SLVERR;
    end
    next_st.awready = ~next_st.aw_held & ~next_st.bvalid;
    next_st.wready  = ~next_st.w_held & ~next_st.bvalid;

    // Counter steps on envelope rises; a software load wins
    if (cnt_step)
    begin
      next_st.counter = cnt_next;
    end
    if (do_write && next_st.wlane)
    begin
      if (next_st.wsel.mask)
      begin
        // Assumes search mode was selected before this write
        next_st.mask = next_st.wdata;
      end
      if (next_st.wsel.eqctl)
      begin
        next_st.eqctl = next_st.wdata;
      end
      if (next_st.wsel.cnt_lo)
      begin
        next_st.lo_buf = next_st.wdata;
      end
      if (next_st.wsel.cnt_hi)
      begin
        next_st.counter = {next_st.wdata, st.lo_buf};
      end
    end

    // Read channel
    case (st.rd)
      aei_pkg::RD_IDLE:
      begin
        if (ar_take)
        begin
          next_st.rd      = aei_pkg::RD_RESP;
          next_st.arready = 1'b0;
          next_st.rvalid  = 1'b1;
          next_st.rresp   = (rsel != '0) ? aei_pkg::RESP_OKAY
                                         : aei_pkg::RESP_SLVERR;
          next_st.rdata   = 8'h00; // Mask register reads as zero
          if (rsel.edge_ev)
          begin
            next_st.rdata = st.flags;
          end
          if (rsel.live)
          begin
            next_st.rdata = {5'h00, det_v};
          end
          if (rsel.cnt_lo)
          begin
            // High byte frozen so the pair is coherent
            next_st.rdata   = st.counter[7:0];
            next_st.hi_snap = st.counter[15:8];
          end
          if (rsel.cnt_hi)
          begin
            next_st.rdata = st.hi_snap;
          end
          if (rsel.speed)
          begin
            next_st.rdata = st.speed;
          end
          if (rsel.eqctl)
          begin
            next_st.rdata = st.eqctl;
          end
        end
      end
      aei_pkg::RD_RESP:
      begin
        if (rready)
        begin
          next_st.rd      = aei_pkg::RD_IDLE;
          next_st.rvalid  = 1'b0;
          next_st.arready = 1'b1;
        end
      end
      default:
      begin
        next_st.rd      = aei_pkg::RD_IDLE;
        next_st.rvalid  = 1'b0;
        next_st.arready = 1'b1;
      end
    endcase

    // Flags: a new event wins over the clear of the same cycle
    next_st.flags = (st.flags & ~clr)
                    | {coef_bank_switched, 1'b0, ev};
    // Pending only gathers interrupts outside bypass
    next_st.pending = (st.pending & ~edge_read)
                      | ((|ev) & (bypass == aei_pkg::BP_NONE));
    if (bypass != aei_pkg::BP_NONE)
    begin
      next_st.irq_pin = sel_level(bypass, det_v);
    end
    else
    begin
      next_st.irq_pin = ~next_st.pending;
    end
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st         <= '0;
      st.mask    <= aei_pkg::MASK_RST;
      st.eqctl   <= aei_pkg::EQCTL_RST;
      st.counter <= aei_pkg::CNT_RST;
      st.irq_pin <= 1'b1;
      st.awready <= 1'b1;
      st.wready  <= 1'b1;
      st.arready <= 1'b1;
      st.rd      <= aei_pkg::RD_IDLE;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs straight from state
  assign awready     = st.awready;
  assign wready      = st.wready;
  assign bvalid      = st.bvalid;
  assign bresp       = st.bresp;
  assign arready     = st.arready;
  assign rvalid      = st.rvalid;
  assign rresp       = st.rresp;
  assign rdata       = {24'h000000, st.rdata};
  assign eq_mode     = st.eqctl[1:0];
  assign irq_out_pin = st.irq_pin;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  mask_reset_zero_a: assert property (
    !$past(aresetn) |-> (st.mask == 8'h00) && irq_out_pin)
    else $error("mask not zero after reset");

  bypass_level_a: assert property (
    (bypass != 2'h0) |=> (irq_out_pin == $past(sel_level(bypass, det_v))))
    else $error("bypass pin does not follow level");

  bypass_marker_a: assert property (
    (bypass == 2'h1) |=> (irq_out_pin == $past(det_in.marker)))
    else $error("code 01 must route marker level");

  pin_low_event_a: assert property (
    ((bypass == 2'h0) && (|ev)) |=> !irq_out_pin)
    else $error("enabled event did not pull pin low");

  pin_held_a: assert property (
    ((bypass == 2'h0) && !irq_out_pin && !edge_read
     && $stable(bypass)) |=> !irq_out_pin)
    else $error("pin released without status read");

  flag_accum_a: assert property (
    (|ev) |=> ((st.flags[5:0] & $past(ev)) == $past(ev)))
    else $error("enabled event not recorded");

  read_clear_a: assert property (
    (edge_read && !(|ev) && !coef_bank_switched) ##1 rvalid
    |-> (st.flags == 8'h00) && (rdata[7:0] == $past(st.flags)))
    else $error("status read did not clear returned flags");

  rearm_a: assert property (
    (edge_read ##1 ((|ev) && (bypass == 2'h0))) |=> !irq_out_pin)
    else $error("event after read did not rearm pin");

  count_step_a: assert property (
    (cnt_step && !do_write) |=>
    (st.counter == $past(cnt_next)) && (st.counter != $past(st.counter)))
    else $error("counter did not step by one");

  count_zero_a: assert property (
    (cnt_step && (cnt_next == 16'h0000) && st.mask[0])
    |=> st.flags[0])
    else $error("count zero event missing");

  side_free_read_a: assert property (
    (ar_take && (rsel.live || rsel.speed) && !(|ev)
     && !coef_bank_switched && !cnt_step && !do_write)
    |=> $stable(st.flags) && $stable(st.counter))
    else $error("side effect on live or speed read");

  speed_layout_a: assert property (
    (ar_take && rsel.speed) |=>
    rvalid && (rdata[7] == $past(st.speed.invalid))
    && (rdata[6:2] == $past(st.speed.value)))
    else $error("search rate register layout wrong");

  byte_pair_a: assert property (
    (ar_take && rsel.cnt_lo) |=>
    (st.hi_snap == $past(st.counter[15:8]))
    && (rdata[7:0] == $past(st.counter[7:0])))
    else $error("counter low byte read wrong");

  // Live read data, pin release on read, counter load, bank flag and bypass gating
  live_read_a: assert property (
    (ar_take && rsel.live) |=>
    rvalid && (rdata[7:0] == {5'h00, $past(det_in)}))
    else $error("live level read wrong");

  read_release_a: assert property (
    ((bypass == 2'h0) && edge_read && !(|ev)) |=> irq_out_pin)
    else $error("pin not released by status read");

  count_load_a: assert property (
    (do_write && next_st.wlane && next_st.wsel.cnt_hi) |=>
    (st.counter == {$past(next_st.wdata), $past(st.lo_buf)}))
    else $error("counter byte pair load wrong");

  bank_flag_a: assert property (
    coef_bank_switched |=> st.flags[7] && !st.flags[6])
    else $error("bank switch flag not set");

  bypass_no_irq_a: assert property (
    ((bypass != 2'h0) && !st.pending) |=> !st.pending)
    else $error("interrupt gathered in bypass");

endmodule // aei_top
